// ### verilog/spg_port.sv
// Functional notes
// RULE1 - bits 7..0 map to pins eleven..four
// RULE2 - disabled pin stays high impedance
// RULE3 - input: 00 plain, 10 pulldown, 11 pullup
// RULE4 - output: 00 pushpull, 11 high-side, 10 low-side
// RULE5 - control pair 01 behaves as 00
// RULE6 - electrode selection overrides port enable; code applies it only in run mode
// RULE7 - reset leaves all pins disabled
// RULE8 - control writes accepted in any mode
// RULE9 - enabled output drives its level bit
// RULE10 - output changes wait for conversion done; code holds them only while charging
// RULE11 - output pins read stored bit
// RULE12 - input pins read latched pin level
// RULE13 - level writes stored for input pins
// RULE14 - set clear invert touch only one-bits
// RULE15 - set clear invert read level register
// RULE16 - key 0x63 at 0x80 soft resets
// RULE17 - inputs pass two-stage synchroniser
module spg_port (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire spg_pkg::spg_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic [7:0] electrode_sel,
  input wire logic run_mode,
  input wire logic charging,
  input wire logic conv_done,
  input wire logic [7:0] pin_i,
  output spg_pkg::spg_pad_t pad
);
  import spg_pkg::*;

  logic [7:0] cfg_a_q, cfg_b_q, level_q, dir_q, en_q;
  logic [7:0] drive_q;
  logic [7:0] pin_s;
  logic [7:0] pin_lat_q;
  logic soft_rst_q;
  logic [7:0] act;
  spg_pad_t pad_d;

  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    case (a)
      OFF_CFG_A: rd_mux = cfg_a_q;
      OFF_CFG_B: rd_mux = cfg_b_q;
      OFF_DIR: rd_mux = dir_q;
      OFF_EN: rd_mux = en_q;
      OFF_LEVEL, OFF_SET, OFF_CLEAR, OFF_INV:
        rd_mux = (dir_q & level_q) | (~dir_q & pin_lat_q); // [RULE11] [RULE12] [RULE15]
      default: rd_mux = RD_UNMAPPED;
    endcase
  endfunction : rd_mux

  ////////////////////////////////////////////////////////////////
  spg_sync u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d(pin_i),
    .q(pin_s)
  );

  // soft reset strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= req.wr && req.addr == OFF_SRST && req.wdata == SRST_KEY; // [RULE16]
    end
  end

  // config registers, writable in any mode
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_a_q <= RST_BYTE;
      cfg_b_q <= RST_BYTE;
      dir_q <= RST_BYTE;
      en_q <= RST_BYTE; // [RULE7]
    end else if (soft_rst_q) begin
      cfg_a_q <= RST_BYTE; // [RULE16]
      cfg_b_q <= RST_BYTE;
      dir_q <= RST_BYTE;
      en_q <= RST_BYTE;
    end else if (req.wr) begin
      case (req.addr) // [RULE8]
        OFF_CFG_A: cfg_a_q <= req.wdata;
        OFF_CFG_B: cfg_b_q <= req.wdata;
        OFF_DIR: dir_q <= req.wdata;
        OFF_EN: en_q <= req.wdata;
        default: ;
      endcase
    end
  end

  // level register with atomic updates
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= RST_BYTE;
    end else if (soft_rst_q) begin
      level_q <= RST_BYTE;
    end else if (req.wr) begin
      case (req.addr)
        OFF_LEVEL: level_q <= req.wdata; // [RULE13]
        OFF_SET: level_q <= level_q | req.wdata; // [RULE14]
        OFF_CLEAR: level_q <= level_q & ~req.wdata; // [RULE14]
        OFF_INV: level_q <= level_q ^ req.wdata; // [RULE14]
        default: ;
      endcase
    end
  end

  // drive level held during charging until conversion done
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_q <= RST_BYTE;
    end else if (soft_rst_q) begin
      drive_q <= RST_BYTE;
    end else if (!charging || conv_done) begin
      drive_q <= level_q; // [RULE10] [RULE9]
    end
  end

  // input latch
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_lat_q <= RST_BYTE;
    end else begin
      pin_lat_q <= pin_s; // [RULE17]
    end
  end

  // read port
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= RST_BYTE;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= rd_mux(req.addr);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin function decode, bit i is pin i+4
  assign act = en_q & ~(electrode_sel & {8{run_mode}}); // [RULE2] [RULE6] [RULE1]

  always_comb begin
    pad_d = '0;
    for (int i = 0; i < 8; i++) begin
      if (act[i] && !dir_q[i]) begin
        pad_d.pd[i] = cfg_a_q[i] && !cfg_b_q[i]; // [RULE3] [RULE5]
        pad_d.pu[i] = cfg_a_q[i] && cfg_b_q[i]; // [RULE3]
      end else if (act[i]) begin
        pad_d.o[i] = drive_q[i]; // [RULE9]
        if (cfg_a_q[i] && cfg_b_q[i]) begin
          pad_d.oe[i] = drive_q[i]; // [RULE4]
        end else if (cfg_a_q[i]) begin
          pad_d.oe[i] = !drive_q[i]; // [RULE4]
        end else begin
          pad_d.oe[i] = 1'b1; // [RULE4] [RULE5]
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pad <= '0; // [RULE7]
    end else begin
      pad <= pad_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  AST_DISABLED_HIZ: assert property ( // [RULE2]
    @(posedge ref_clk) disable iff (!rst_b)
    (en_q == 8'h00) |=> ((pad.oe | pad.pu | pad.pd) == 8'h00))
    else $error("disabled pin driven");

  AST_ELECTRODE_WINS: assert property ( // [RULE6]
    @(posedge ref_clk) disable iff (!rst_b)
    run_mode |=> (((pad.oe | pad.pu | pad.pd) & $past(electrode_sel)) == 8'h00))
    else $error("electrode pin driven");

  AST_PUSHPULL: assert property ( // [RULE4]
    @(posedge ref_clk) disable iff (!rst_b)
    (act[0] && dir_q[0] && !cfg_a_q[0]) |=> pad.oe[0])
    else $error("push-pull not enabled");

  AST_SET: assert property ( // [RULE14]
    @(posedge ref_clk) disable iff (!rst_b || soft_rst_q)
    req.wr && req.addr == OFF_SET |=> level_q == ($past(level_q) | $past(req.wdata)))
    else $error("set wrong");

  AST_CLEAR: assert property ( // [RULE14]
    @(posedge ref_clk) disable iff (!rst_b || soft_rst_q)
    req.wr && req.addr == OFF_CLEAR |=> level_q == ($past(level_q) & ~$past(req.wdata)))
    else $error("clear wrong");

  AST_INVERT: assert property ( // [RULE14]
    @(posedge ref_clk) disable iff (!rst_b || soft_rst_q)
    req.wr && req.addr == OFF_INV |=> level_q == ($past(level_q) ^ $past(req.wdata)))
    else $error("invert wrong");

  AST_LEVEL_WRITE: assert property ( // [RULE13]
    @(posedge ref_clk) disable iff (!rst_b || soft_rst_q)
    req.wr && req.addr == OFF_LEVEL |=> level_q == $past(req.wdata))
    else $error("level write lost");

  AST_CFG_A_WRITE: assert property ( // [RULE8]
    @(posedge ref_clk) disable iff (!rst_b || soft_rst_q)
    req.wr && req.addr == OFF_CFG_A |=> cfg_a_q == $past(req.wdata))
    else $error("config a write lost");

  AST_CFG_B_WRITE: assert property ( // [RULE8]
    @(posedge ref_clk) disable iff (!rst_b || soft_rst_q)
    req.wr && req.addr == OFF_CFG_B |=> cfg_b_q == $past(req.wdata))
    else $error("config b write lost");

  AST_DIR_WRITE: assert property ( // [RULE8]
    @(posedge ref_clk) disable iff (!rst_b || soft_rst_q)
    req.wr && req.addr == OFF_DIR |=> dir_q == $past(req.wdata))
    else $error("direction write lost");

  AST_EN_WRITE: assert property ( // [RULE8]
    @(posedge ref_clk) disable iff (!rst_b || soft_rst_q)
    req.wr && req.addr == OFF_EN |=> en_q == $past(req.wdata))
    else $error("enable write lost");

  AST_PLAIN_INPUT: assert property ( // [RULE3] [RULE5]
    @(posedge ref_clk) disable iff (!rst_b)
    act[1] && !dir_q[1] && !cfg_a_q[1] |=> !(pad.oe[1] || pad.pu[1] || pad.pd[1]))
    else $error("plain input not floating");

  AST_PULLDOWN: assert property ( // [RULE3]
    @(posedge ref_clk) disable iff (!rst_b)
    act[2] && !dir_q[2] && cfg_a_q[2] && !cfg_b_q[2] |=> pad.pd[2] && !pad.pu[2])
    else $error("pulldown missing");

  AST_PULLUP: assert property ( // [RULE3]
    @(posedge ref_clk) disable iff (!rst_b)
    act[3] && !dir_q[3] && cfg_a_q[3] && cfg_b_q[3] |=> pad.pu[3] && !pad.pd[3])
    else $error("pullup missing");

  AST_INPUT_NO_DRIVE: assert property ( // [RULE3]
    @(posedge ref_clk) disable iff (!rst_b)
    dir_q == 8'h00 |=> pad.oe == 8'h00)
    else $error("input pin driven");

  AST_HIGH_SIDE: assert property ( // [RULE4]
    @(posedge ref_clk) disable iff (!rst_b)
    act[7] && dir_q[7] && cfg_a_q[7] && cfg_b_q[7] |=> pad.oe[7] == $past(drive_q[7]))
    else $error("high-side drive wrong");

  AST_LOW_SIDE: assert property ( // [RULE4]
    @(posedge ref_clk) disable iff (!rst_b)
    act[6] && dir_q[6] && cfg_a_q[6] && !cfg_b_q[6] |=> pad.oe[6] == !$past(drive_q[6]))
    else $error("low-side drive wrong");

  AST_OPTION_01_OUT: assert property ( // [RULE5]
    @(posedge ref_clk) disable iff (!rst_b)
    act[5] && dir_q[5] && !cfg_a_q[5] && cfg_b_q[5] |=> pad.oe[5])
    else $error("pair 01 output not push-pull");

  AST_OPTION_01_IN: assert property ( // [RULE5]
    @(posedge ref_clk) disable iff (!rst_b)
    act[5] && !dir_q[5] && !cfg_a_q[5] && cfg_b_q[5] |=> !(pad.pu[5] || pad.pd[5]))
    else $error("pair 01 input has a pull");

  AST_OUTPUT_LEVEL: assert property ( // [RULE9]
    @(posedge ref_clk) disable iff (!rst_b)
    act[4] && dir_q[4] |=> pad.o[4] == $past(drive_q[4]))
    else $error("output level wrong");

  AST_HOLD_CHARGE: assert property ( // [RULE10]
    @(posedge ref_clk) disable iff (!rst_b || soft_rst_q)
    charging && !conv_done |=> $stable(drive_q))
    else $error("output moved while charging");

  AST_DRIVE_UPDATE: assert property ( // [RULE10] [RULE9]
    @(posedge ref_clk) disable iff (!rst_b || soft_rst_q)
    !charging || conv_done |=> drive_q == $past(level_q))
    else $error("output level not updated");

  AST_PULL_EXCLUSIVE: assert property ( // [RULE3]
    @(posedge ref_clk) disable iff (!rst_b)
    (pad.pu & pad.pd) == 8'h00)
    else $error("pullup and pulldown together");

  AST_DRIVE_NO_PULL: assert property ( // [RULE3] [RULE4]
    @(posedge ref_clk) disable iff (!rst_b)
    (pad.oe & (pad.pu | pad.pd)) == 8'h00)
    else $error("driven pin also pulled");

  AST_SOFT_RESET: assert property ( // [RULE16]
    @(posedge ref_clk) disable iff (!rst_b)
    req.wr && req.addr == OFF_SRST && req.wdata == SRST_KEY |=> ##1 en_q == 8'h00)
    else $error("soft reset missed");

  AST_KEY_ONLY: assert property ( // [RULE16]
    @(posedge ref_clk) disable iff (!rst_b)
    req.wr && req.addr == OFF_SRST && req.wdata != SRST_KEY |=> !soft_rst_q)
    else $error("soft reset without key");

  AST_SOFT_CLEARS: assert property ( // [RULE16]
    @(posedge ref_clk) disable iff (!rst_b)
    soft_rst_q |=> (level_q | drive_q | cfg_a_q | cfg_b_q | dir_q | en_q) == 8'h00)
    else $error("soft reset left state");

  AST_SOFT_PADS: assert property ( // [RULE7] [RULE16]
    @(posedge ref_clk) disable iff (!rst_b)
    soft_rst_q |=> ##1 ({pad.o, pad.oe, pad.pu, pad.pd} == 32'h0))
    else $error("pads active after soft reset");

  AST_READ_OUT: assert property ( // [RULE15]
    @(posedge ref_clk) disable iff (!rst_b)
    req.rd && req.addr == OFF_INV && dir_q == 8'hff |=> rdata == $past(level_q))
    else $error("read of output level wrong");

  AST_READ_SET: assert property ( // [RULE15]
    @(posedge ref_clk) disable iff (!rst_b)
    req.rd && req.addr == OFF_SET && dir_q == 8'hff |=> rdata == $past(level_q))
    else $error("read of set register wrong");

  AST_READ_CLEAR: assert property ( // [RULE15]
    @(posedge ref_clk) disable iff (!rst_b)
    req.rd && req.addr == OFF_CLEAR && dir_q == 8'hff |=> rdata == $past(level_q))
    else $error("read of clear register wrong");

  AST_READ_LEVEL_OUT: assert property ( // [RULE11]
    @(posedge ref_clk) disable iff (!rst_b)
    req.rd && req.addr == OFF_LEVEL && dir_q == 8'hff |=> rdata == $past(level_q))
    else $error("read of stored level wrong");

  AST_READ_IN: assert property ( // [RULE12]
    @(posedge ref_clk) disable iff (!rst_b)
    req.rd && req.addr == OFF_LEVEL && dir_q == 8'h00 |=> rdata == $past(pin_lat_q))
    else $error("read of input level wrong");

  AST_READ_ANSWER: assert property ( // [RULE11] [RULE12]
    @(posedge ref_clk) disable iff (!rst_b)
    req.rd |=> rvalid)
    else $error("read not answered");

  AST_LATCH_FOLLOWS: assert property ( // [RULE17]
    @(posedge ref_clk) disable iff (!rst_b)
    pin_lat_q == $past(pin_s))
    else $error("input latch lagging");

  COV_SOFT: cover property (@(posedge ref_clk) disable iff (!rst_b) soft_rst_q);
  COV_LED: cover property (@(posedge ref_clk) disable iff (!rst_b)
    act[7] && dir_q[7] && cfg_a_q[7] && cfg_b_q[7]);
  COV_PULLUP: cover property (@(posedge ref_clk) disable iff (!rst_b) pad.pu != 8'h00);
  COV_ELECTRODE: cover property (@(posedge ref_clk) disable iff (!rst_b)
    run_mode && ((electrode_sel & en_q) != 8'h00));
  COV_HOLD: cover property (@(posedge ref_clk) disable iff (!rst_b)
    charging && !conv_done && (drive_q != level_q));
endmodule : spg_port

// ### verilog/spg_pkg.sv
package spg_pkg;
  localparam logic [7:0] OFF_CFG_A = 8'h73;
  localparam logic [7:0] OFF_CFG_B = 8'h74;
  localparam logic [7:0] OFF_LEVEL = 8'h75;
  localparam logic [7:0] OFF_DIR = 8'h76;
  localparam logic [7:0] OFF_EN = 8'h77;
  localparam logic [7:0] OFF_SET = 8'h78;
  localparam logic [7:0] OFF_CLEAR = 8'h79;
  localparam logic [7:0] OFF_INV = 8'h7a;
  localparam logic [7:0] OFF_SRST = 8'h80;
  localparam logic [7:0] SRST_KEY = 8'h63;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spg_req_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu;
    logic [7:0] pd;
  } spg_pad_t;
endpackage : spg_pkg

// ### verilog/spg_sync.sv
module spg_sync (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] d,
  output logic [7:0] q
);
  import spg_pkg::*;
  logic [7:0] s1_q;

  // two-stage synchroniser
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= RST_BYTE;
      q <= RST_BYTE;
    end else begin
      s1_q <= d; // [RULE17]
      q <= s1_q; // [RULE17]
    end
  end
endmodule : spg_sync

// ### verif/spg_pad_model.sv
module spg_pad_model (
  input wire logic ref_clk,
  input wire spg_pkg::spg_pad_t pad,
  input wire logic ext_en,
  input wire logic [7:0] ext_v,
  output logic [7:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import spg_pkg::*;
  logic flip_q = 1'b0;
  always @(posedge ref_clk) flip_q <= ~flip_q;
  // pad level: own drive, outside drive, pull, else floating pattern
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.oe[i]) pin_i[i] = pad.o[i];
      else if (ext_en) pin_i[i] = ext_v[i];
      else if (pad.pu[i]) pin_i[i] = 1'b1;
      else if (pad.pd[i]) pin_i[i] = 1'b0;
      else pin_i[i] = flip_q;
    end
  end
endmodule : spg_pad_model

// ### verif/spg_port_test.sv
module spg_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  import spg_pkg::*;
  logic ref_clk, rst_b, run_mode, charging, conv_done, ext_en, rvalid;
  logic [7:0] electrode_sel, ext_v, pin_i, rdata, lv, r, a, b;
  spg_req_t req;
  spg_pad_t pad;
  logic [7:0] exp_q[$];
  int error_cnt, checks;
  spg_port uut (.ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rdata(rdata),
    .rvalid(rvalid), .electrode_sel(electrode_sel), .run_mode(run_mode),
    .charging(charging), .conv_done(conv_done), .pin_i(pin_i), .pad(pad));
  spg_pad_model pm (.ref_clk(ref_clk), .pad(pad), .ext_en(ext_en), .ext_v(ext_v),
    .pin_i(pin_i));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic op(logic w, logic [7:0] ad, logic [7:0] d);
    @(negedge ref_clk);
    req <= '{wr: w, rd: !w, addr: ad, wdata: d};
    @(negedge ref_clk);
    req <= '0;
  endtask : op
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    op(1'b1, ad, d);
  endtask : wr
  task automatic rd(logic [7:0] ad, logic [7:0] e);
    exp_q.push_back(e);
    op(1'b0, ad, 8'h00);
  endtask : rd
  task automatic pad_is(logic [7:0] o, logic [7:0] oe, logic [7:0] pu, logic [7:0] pd);
    repeat (3) @(negedge ref_clk);
    chk({pad.o & pad.oe, pad.oe, pad.pu, pad.pd}, {o & oe, oe, pu, pd});
  endtask : pad_is
  always @(negedge ref_clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk({24'h0, rdata}, {24'h0, exp_q.pop_front()});
    end
  end
  initial begin
    rst_b = 1'b0;
    req = '0;
    electrode_sel = 8'h00;
    {run_mode, charging, conv_done, ext_en} = 4'h0;
    ext_v = 8'h00;
    r = 8'($urandom(72));
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    rd(OFF_CFG_A, 8'h00);
    rd(OFF_EN, 8'h00);
    rd(8'h55, 8'h00);
    pad_is(8'h00, 8'h00, 8'h00, 8'h00);
    wr(OFF_EN, 8'hff);
    lv = 8'($urandom);
    wr(OFF_LEVEL, lv);
    for (int m = 0; m < 4; m++) begin
      a = {8{m[1]}};
      b = {8{m[0]}};
      wr(OFF_CFG_A, a);
      wr(OFF_CFG_B, b);
      wr(OFF_DIR, 8'hff);
      rd(OFF_CFG_B, b);
      pad_is(lv, (m == 3) ? lv : (m == 2) ? ~lv : 8'hff, 8'h00, 8'h00);
      rd(OFF_LEVEL, lv);
      wr(OFF_DIR, 8'h00);
      pad_is(8'h00, 8'h00, (m == 3) ? 8'hff : 8'h00, (m == 2) ? 8'hff : 8'h00);
    end
    ext_en = 1'b1;
    ext_v = 8'($urandom);
    lv = 8'($urandom);
    wr(OFF_LEVEL, lv);
    repeat (4) @(negedge ref_clk);
    rd(OFF_LEVEL, ext_v);
    ext_en = 1'b0;
    wr(OFF_DIR, 8'hff);
    rd(OFF_LEVEL, lv);
    for (int k = 0; k < 3; k++) begin
      r = 8'($urandom);
      wr(8'(OFF_SET + k), r);
      lv = (k == 0) ? lv | r : (k == 1) ? lv & ~r : lv ^ r;
      rd(8'(OFF_SET + k), lv);
    end
    pad_is(lv, lv, 8'h00, 8'h00);
    charging = 1'b1;
    wr(OFF_INV, 8'hff);
    pad_is(lv, lv, 8'h00, 8'h00);
    lv = ~lv;
    conv_done = 1'b1;
    @(negedge ref_clk);
    conv_done = 1'b0;
    pad_is(lv, lv, 8'h00, 8'h00);
    charging = 1'b0;
    run_mode = 1'b1;
    electrode_sel = 8'h0f;
    pad_is(lv & 8'hf0, lv & 8'hf0, 8'h00, 8'h00);
    wr(OFF_SRST, 8'h12);
    rd(OFF_EN, 8'hff);
    wr(OFF_SRST, SRST_KEY);
    rd(OFF_EN, 8'h00);
    pad_is(8'h00, 8'h00, 8'h00, 8'h00);
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge ref_clk);
    if (exp_q.size() > 0) error_cnt++;
    print_verdict();
  end
endmodule : spg_port_test
